// *** hw/sysreg_rom_pkg.sv ***
// Shared offsets, field positions, reset values and timing for the system register bank
package sysreg_rom_pkg;
    localparam int         ADDR_W          = 10;
    localparam int         NIB_W           = 4;
    localparam int         PROG_ADDR_W     = 12;
    localparam int         PROG_WORD_W     = 16;
    localparam int         PROG_DEPTH      = 4096;
    localparam int         CONV_W          = 10;

    localparam logic [9:0] ADDR_PORT_C_DIR = 10'h01a;
    localparam logic [9:0] ADDR_PORT_D_DIR = 10'h01b;
    localparam logic [9:0] ADDR_PORT_E_DIR = 10'h01c;
    localparam logic [9:0] ADDR_WDOG_CTRL  = 10'h01e;
    localparam logic [9:0] ADDR_PWM_A_CTRL = 10'h020;
    localparam logic [9:0] ADDR_PWM_B_CTRL = 10'h021;
    localparam logic [9:0] ADDR_PWM_A_PLO  = 10'h022;
    localparam logic [9:0] ADDR_PWM_A_PHI  = 10'h023;
    localparam logic [9:0] ADDR_PWM_A_FINE = 10'h024;
    localparam logic [9:0] ADDR_PWM_A_DLO  = 10'h025;
    localparam logic [9:0] ADDR_PWM_A_DHI  = 10'h026;
    localparam logic [9:0] ADDR_PWM_B_PLO  = 10'h027;
    localparam logic [9:0] ADDR_PWM_B_PHI  = 10'h028;
    localparam logic [9:0] ADDR_PWM_B_FINE = 10'h029;
    localparam logic [9:0] ADDR_PWM_B_DLO  = 10'h02a;
    localparam logic [9:0] ADDR_PWM_B_DHI  = 10'h02b;
    localparam logic [9:0] ADDR_CONV_LOW   = 10'h02d;
    localparam logic [9:0] ADDR_CONV_MID   = 10'h02e;
    localparam logic [9:0] ADDR_CONV_HIGH  = 10'h02f;
    localparam logic [9:0] ADDR_TABLE_N0   = 10'h380;
    localparam logic [9:0] ADDR_TABLE_N1   = 10'h381;
    localparam logic [9:0] ADDR_TABLE_N2   = 10'h382;
    localparam logic [9:0] ADDR_TABLE_N3   = 10'h383;
    localparam logic [9:0] ADDR_PD_IRQ_EN  = 10'h384;
    localparam logic [9:0] ADDR_PD_IRQ_REQ = 10'h385;
    localparam logic [9:0] ADDR_PB_IRQ_EN  = 10'h386;
    localparam logic [9:0] ADDR_PB_IRQ_REQ = 10'h387;
    localparam logic [9:0] ADDR_PA_PULLUP  = 10'h388;
    localparam logic [9:0] ADDR_PB_PULLUP  = 10'h389;
    localparam logic [9:0] ADDR_PC_PULLUP  = 10'h38a;
    localparam logic [9:0] ADDR_PD_PULLUP  = 10'h38b;
    localparam logic [9:0] ADDR_PE_PULLUP  = 10'h38c;

    localparam int         WDOG_FLAG_BIT   = 3;
    localparam int         PWM_EN_BIT      = 0;
    localparam int         PWM_CLK_LSB     = 1;
    localparam int         PWM_MODE_BIT    = 3;

    localparam logic [3:0] NIB_RESET       = 4'h0;
    localparam logic [2:0] WDOG_FIELD_RST  = 3'h0;

    localparam logic [11:0] VEC_RESET      = 12'h000;
    localparam logic [11:0] VEC_CONVERTER  = 12'h001;
    localparam logic [11:0] VEC_TIMER_A    = 12'h002;
    localparam logic [11:0] VEC_TIMER_B    = 12'h003;
    localparam logic [11:0] VEC_PORT_BD    = 12'h004;

    localparam int         INSTR_CLOCKS    = 4;
    localparam logic [2:0] TABLE_FETCH_CYC = 3'(INSTR_CLOCKS);
endpackage : sysreg_rom_pkg

// *** hw/sysreg_rom_table_reader.sv ***
// Upper system register bank with program store and table read port
// What this block does
// - Watchdog control bits 2..0 are a read/write field.
// - Watchdog bit 3 is the overflow flag; software writes ignored.
// - Channel A control: bit0 enable, bits 2..1 clock select, bit3 mode.
// - Channel B control uses the same layout as channel A.
// - Channel A period is two writable nibbles, low then high.
// - Channel A duty is two fine bits plus low and high nibbles.
// - Channel B period is two writable nibbles, low then high.
// - Channel B duty is two fine bits plus low and high nibbles.
// - Conversion result read only, split 2/4/4 bits over three registers.
// - Port D interrupt enable nibble, read/write.
// - Port D interrupt request nibble, read/write.
// - Port B interrupt enable nibble, read/write.
// - Port B interrupt request nibble, read/write.
// - Program store holds 4096 sixteen-bit words, addresses 0 to 0xfff.
// - Words 0 to 4 are reset and interrupt entry points.
// - Table port takes 12-bit address writes, returns 16-bit word reads.
// - Lowest nibble write starts fetch; word appears one instruction later.
// - Unimplemented bits and reserved locations read as zero.
// - Ordinary reset clears watchdog register; watchdog reset leaves 1000.
`timescale 1ns/1ps
module sysreg_rom_table_reader
    import sysreg_rom_pkg::*;
(
    input  wire logic [9:0]  addr_in,
    input  wire logic        wr_en_in,
    input  wire logic [3:0]  wr_data_in,
    input  wire logic        rd_en_in,
    output logic      [3:0]  rd_data_out,
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        wdog_reset_in,
    input  wire logic [9:0]  conversion_result_in,
    input  wire logic [3:0]  port_b_fall_in,
    input  wire logic [3:0]  port_d_fall_in,
    input  wire logic        prog_wr_en_in,
    input  wire logic [11:0] prog_addr_in,
    input  wire logic [15:0] prog_data_in,
    input  wire logic [11:0] fetch_addr_in,
    output logic      [15:0] fetch_word_out,
    output logic      [3:0]  port_c_dir_bits_out,
    output logic      [3:0]  port_d_dir_bits_out,
    output logic             port_e_dir_bit_out,
    output logic      [2:0]  watchdog_ctrl_field_out,
    output logic             watchdog_overflow_flag_out,
    output logic      [3:0]  pwm_a_control_out,
    output logic      [3:0]  pwm_b_control_out,
    output logic      [7:0]  pwm_a_period_out,
    output logic      [7:0]  pwm_b_period_out,
    output logic      [9:0]  pwm_a_duty_out,
    output logic      [9:0]  pwm_b_duty_out,
    output logic      [3:0]  port_d_irq_enable_bits_out,
    output logic      [3:0]  port_d_irq_request_bits_out,
    output logic      [3:0]  port_b_irq_enable_bits_out,
    output logic      [3:0]  port_b_irq_request_bits_out,
    output logic      [3:0]  port_a_pullup_bits_out,
    output logic      [3:0]  port_b_pullup_bits_out,
    output logic      [3:0]  port_c_pullup_bits_out,
    output logic      [3:0]  port_d_pullup_bits_out,
    output logic             port_e_pullup_bit_out,
    output logic             table_busy_out
);

    logic [15:0] prog_store [0:PROG_DEPTH-1];

    logic [3:0]  port_c_dir_q;
    logic [3:0]  port_d_dir_q;
    logic        port_e_dir_q;
    logic [2:0]  wdog_field_q;
    logic        wdog_flag_q;
    logic [3:0]  pwm_a_ctrl_q;
    logic [3:0]  pwm_b_ctrl_q;
    logic [7:0]  pwm_a_period_q;
    logic [7:0]  pwm_b_period_q;
    logic [1:0]  pwm_a_fine_q;
    logic [1:0]  pwm_b_fine_q;
    logic [7:0]  pwm_a_duty_q;
    logic [7:0]  pwm_b_duty_q;
    logic [3:0]  pd_irq_en_q;
    logic [3:0]  pd_irq_req_q;
    logic [3:0]  pb_irq_en_q;
    logic [3:0]  pb_irq_req_q;
    logic [3:0]  pa_pull_q;
    logic [3:0]  pb_pull_q;
    logic [3:0]  pc_pull_q;
    logic [3:0]  pd_pull_q;
    logic        pe_pull_q;
    logic [11:0] table_addr_q;
    logic [15:0] table_word_q;
    logic [2:0]  fetch_count_q;
    logic [3:0]  rd_data_q;
    logic [15:0] fetch_word_q;
    logic        table_busy_q;

    // Write strobes
    wire wr_pc_dir  = wr_en_in && addr_in == ADDR_PORT_C_DIR;
    wire wr_pd_dir  = wr_en_in && addr_in == ADDR_PORT_D_DIR;
    wire wr_pe_dir  = wr_en_in && addr_in == ADDR_PORT_E_DIR;
    wire wr_wdog    = wr_en_in && addr_in == ADDR_WDOG_CTRL;
    wire wr_a_ctrl  = wr_en_in && addr_in == ADDR_PWM_A_CTRL;
    wire wr_b_ctrl  = wr_en_in && addr_in == ADDR_PWM_B_CTRL;
    wire wr_a_plo   = wr_en_in && addr_in == ADDR_PWM_A_PLO;
    wire wr_a_phi   = wr_en_in && addr_in == ADDR_PWM_A_PHI;
    wire wr_a_fine  = wr_en_in && addr_in == ADDR_PWM_A_FINE;
    wire wr_a_dlo   = wr_en_in && addr_in == ADDR_PWM_A_DLO;
    wire wr_a_dhi   = wr_en_in && addr_in == ADDR_PWM_A_DHI;
    wire wr_b_plo   = wr_en_in && addr_in == ADDR_PWM_B_PLO;
    wire wr_b_phi   = wr_en_in && addr_in == ADDR_PWM_B_PHI;
    wire wr_b_fine  = wr_en_in && addr_in == ADDR_PWM_B_FINE;
    wire wr_b_dlo   = wr_en_in && addr_in == ADDR_PWM_B_DLO;
    wire wr_b_dhi   = wr_en_in && addr_in == ADDR_PWM_B_DHI;
    wire wr_tab_n0  = wr_en_in && addr_in == ADDR_TABLE_N0;
    wire wr_tab_n1  = wr_en_in && addr_in == ADDR_TABLE_N1;
    wire wr_tab_n2  = wr_en_in && addr_in == ADDR_TABLE_N2;
    wire wr_pd_en   = wr_en_in && addr_in == ADDR_PD_IRQ_EN;
    wire wr_pd_req  = wr_en_in && addr_in == ADDR_PD_IRQ_REQ;
    wire wr_pb_en   = wr_en_in && addr_in == ADDR_PB_IRQ_EN;
    wire wr_pb_req  = wr_en_in && addr_in == ADDR_PB_IRQ_REQ;
    wire wr_pa_pull = wr_en_in && addr_in == ADDR_PA_PULLUP;
    wire wr_pb_pull = wr_en_in && addr_in == ADDR_PB_PULLUP;
    wire wr_pc_pull = wr_en_in && addr_in == ADDR_PC_PULLUP;
    wire wr_pd_pull = wr_en_in && addr_in == ADDR_PD_PULLUP;
    wire wr_pe_pull = wr_en_in && addr_in == ADDR_PE_PULLUP;

    // Table fetch completes when the counter steps from one to zero
    wire fetch_done = fetch_count_q == 3'h1;

    // Read selection; anything unlisted returns zero
    wire [3:0] table_nibble =
        (addr_in == ADDR_TABLE_N0) ? table_word_q[3:0]   :
        (addr_in == ADDR_TABLE_N1) ? table_word_q[7:4]   :
        (addr_in == ADDR_TABLE_N2) ? table_word_q[11:8]  :
                                     table_word_q[15:12];
    wire is_table = addr_in[9:2] == ADDR_TABLE_N0[9:2];
    wire [3:0] read_nibble =
        (addr_in == ADDR_PORT_C_DIR) ? port_c_dir_q                  :
        (addr_in == ADDR_PORT_D_DIR) ? port_d_dir_q                  :
        (addr_in == ADDR_PORT_E_DIR) ? {3'h0, port_e_dir_q}          :
        (addr_in == ADDR_WDOG_CTRL)  ? {wdog_flag_q, wdog_field_q}   :
        (addr_in == ADDR_PWM_A_CTRL) ? pwm_a_ctrl_q                  :
        (addr_in == ADDR_PWM_B_CTRL) ? pwm_b_ctrl_q                  :
        (addr_in == ADDR_PWM_A_PLO)  ? pwm_a_period_q[3:0]           :
        (addr_in == ADDR_PWM_A_PHI)  ? pwm_a_period_q[7:4]           :
        (addr_in == ADDR_PWM_A_FINE) ? {2'h0, pwm_a_fine_q}          :
        (addr_in == ADDR_PWM_A_DLO)  ? pwm_a_duty_q[3:0]             :
        (addr_in == ADDR_PWM_A_DHI)  ? pwm_a_duty_q[7:4]             :
        (addr_in == ADDR_PWM_B_PLO)  ? pwm_b_period_q[3:0]           :
        (addr_in == ADDR_PWM_B_PHI)  ? pwm_b_period_q[7:4]           :
        (addr_in == ADDR_PWM_B_FINE) ? {2'h0, pwm_b_fine_q}          :
        (addr_in == ADDR_PWM_B_DLO)  ? pwm_b_duty_q[3:0]             :
        (addr_in == ADDR_PWM_B_DHI)  ? pwm_b_duty_q[7:4]             :
        (addr_in == ADDR_CONV_LOW)   ? {2'h0, conversion_result_in[1:0]} :
        (addr_in == ADDR_CONV_MID)   ? conversion_result_in[5:2]     :
        (addr_in == ADDR_CONV_HIGH)  ? conversion_result_in[9:6]     :
        is_table                     ? table_nibble                  :
        (addr_in == ADDR_PD_IRQ_EN)  ? pd_irq_en_q                   :
        (addr_in == ADDR_PD_IRQ_REQ) ? pd_irq_req_q                  :
        (addr_in == ADDR_PB_IRQ_EN)  ? pb_irq_en_q                   :
        (addr_in == ADDR_PB_IRQ_REQ) ? pb_irq_req_q                  :
        (addr_in == ADDR_PA_PULLUP)  ? pa_pull_q                     :
        (addr_in == ADDR_PB_PULLUP)  ? pb_pull_q                     :
        (addr_in == ADDR_PC_PULLUP)  ? pc_pull_q                     :
        (addr_in == ADDR_PD_PULLUP)  ? pd_pull_q                     :
        (addr_in == ADDR_PE_PULLUP)  ? {3'h0, pe_pull_q}             :
                                       NIB_RESET;

    // Hardware events win over a software write in the same cycle
    wire [3:0] pd_req_d = (wr_pd_req ? wr_data_in : pd_irq_req_q) | port_d_fall_in;
    wire [3:0] pb_req_d = (wr_pb_req ? wr_data_in : pb_irq_req_q) | port_b_fall_in;

    // Registers cleared by any reset, watchdog reset included
    always_ff @(posedge clock_in) begin
        if (reset_in || wdog_reset_in) begin
            port_c_dir_q <= NIB_RESET;
            port_d_dir_q <= NIB_RESET;
            port_e_dir_q <= 1'b0;
            pd_irq_en_q  <= NIB_RESET;
            pd_irq_req_q <= NIB_RESET;
            pb_irq_en_q  <= NIB_RESET;
            pb_irq_req_q <= NIB_RESET;
            pa_pull_q    <= NIB_RESET;
            pb_pull_q    <= NIB_RESET;
            pc_pull_q    <= NIB_RESET;
            pd_pull_q    <= NIB_RESET;
            pe_pull_q    <= 1'b0;
        end else begin
            if (wr_pc_dir) port_c_dir_q <= wr_data_in;
            if (wr_pd_dir) port_d_dir_q <= wr_data_in;
            if (wr_pe_dir) port_e_dir_q <= wr_data_in[0];
            if (wr_pd_en) pd_irq_en_q <= wr_data_in;
            pd_irq_req_q <= pd_req_d;
            if (wr_pb_en) pb_irq_en_q <= wr_data_in;
            pb_irq_req_q <= pb_req_d;
            if (wr_pa_pull) pa_pull_q <= wr_data_in;
            if (wr_pb_pull) pb_pull_q <= wr_data_in;
            if (wr_pc_pull) pc_pull_q <= wr_data_in;
            if (wr_pd_pull) pd_pull_q <= wr_data_in;
            if (wr_pe_pull) pe_pull_q <= wr_data_in[0];
        end
    end

    // Watchdog control: field cleared by both resets, flag set by watchdog reset
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wdog_field_q <= WDOG_FIELD_RST;
            wdog_flag_q  <= 1'b0;
        end else if (wdog_reset_in) begin
            wdog_field_q <= WDOG_FIELD_RST;
            wdog_flag_q  <= 1'b1;
        end else if (wr_wdog) begin
            wdog_field_q <= wr_data_in[2:0];
        end
    end

    // Channel control: watchdog reset clears only the enable bit
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pwm_a_ctrl_q <= NIB_RESET;
            pwm_b_ctrl_q <= NIB_RESET;
        end else if (wdog_reset_in) begin
            pwm_a_ctrl_q[PWM_EN_BIT] <= 1'b0;
            pwm_b_ctrl_q[PWM_EN_BIT] <= 1'b0;
        end else begin
            if (wr_a_ctrl) pwm_a_ctrl_q <= wr_data_in;
            if (wr_b_ctrl) pwm_b_ctrl_q <= wr_data_in;
        end
    end

    // Period and duty nibbles survive a watchdog reset
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pwm_a_period_q <= 8'h00;
            pwm_b_period_q <= 8'h00;
            pwm_a_fine_q   <= 2'h0;
            pwm_b_fine_q   <= 2'h0;
            pwm_a_duty_q   <= 8'h00;
            pwm_b_duty_q   <= 8'h00;
        end else begin
            if (wr_a_plo) pwm_a_period_q[3:0] <= wr_data_in;
            if (wr_a_phi) pwm_a_period_q[7:4] <= wr_data_in;
            if (wr_a_fine) pwm_a_fine_q <= wr_data_in[1:0];
            if (wr_a_dlo) pwm_a_duty_q[3:0] <= wr_data_in;
            if (wr_a_dhi) pwm_a_duty_q[7:4] <= wr_data_in;
            if (wr_b_plo) pwm_b_period_q[3:0] <= wr_data_in;
            if (wr_b_phi) pwm_b_period_q[7:4] <= wr_data_in;
            if (wr_b_fine) pwm_b_fine_q <= wr_data_in[1:0];
            if (wr_b_dlo) pwm_b_duty_q[3:0] <= wr_data_in;
            if (wr_b_dhi) pwm_b_duty_q[7:4] <= wr_data_in;
        end
    end

    // Table address nibbles; the lowest one arms the fetch counter
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            table_addr_q  <= 12'h000;
            fetch_count_q <= 3'h0;
            table_busy_q  <= 1'b0;
        end else begin
            if (wr_tab_n2) table_addr_q[11:8] <= wr_data_in;
            if (wr_tab_n1) table_addr_q[7:4] <= wr_data_in;
            if (wr_tab_n0) table_addr_q[3:0] <= wr_data_in;
            table_busy_q <= wr_tab_n0 || fetch_count_q > 3'h1;
            if (wr_tab_n0) begin
                fetch_count_q <= TABLE_FETCH_CYC;
            end else if (fetch_count_q != 3'h0) begin
                fetch_count_q <= fetch_count_q - 3'h1;
            end
        end
    end

    // Word appears when the count runs out; until then the old word stays
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            table_word_q <= 16'h0000;
        end else if (fetch_done && !wr_tab_n0) begin
            table_word_q <= prog_store[table_addr_q];
        end
    end

    // Program store, written by the loader, read by core and table port
    always_ff @(posedge clock_in) begin
        if (prog_wr_en_in) begin
            prog_store[prog_addr_in] <= prog_data_in;
        end
    end

    // Core fetch; the vector words at 0..4 are reached this way
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            fetch_word_q <= 16'h0000;
        end else begin
            fetch_word_q <= prog_store[fetch_addr_in];
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rd_data_q <= NIB_RESET;
        end else begin
            rd_data_q <= rd_en_in ? read_nibble : NIB_RESET;
        end
    end

    assign rd_data_out                 = rd_data_q;
    assign fetch_word_out              = fetch_word_q;
    assign port_c_dir_bits_out         = port_c_dir_q;
    assign port_d_dir_bits_out         = port_d_dir_q;
    assign port_e_dir_bit_out          = port_e_dir_q;
    assign watchdog_ctrl_field_out     = wdog_field_q;
    assign watchdog_overflow_flag_out  = wdog_flag_q;
    assign pwm_a_control_out           = pwm_a_ctrl_q;
    assign pwm_b_control_out           = pwm_b_ctrl_q;
    assign pwm_a_period_out            = pwm_a_period_q;
    assign pwm_b_period_out            = pwm_b_period_q;
    assign pwm_a_duty_out              = {pwm_a_duty_q, pwm_a_fine_q};
    assign pwm_b_duty_out              = {pwm_b_duty_q, pwm_b_fine_q};
    assign port_d_irq_enable_bits_out  = pd_irq_en_q;
    assign port_d_irq_request_bits_out = pd_irq_req_q;
    assign port_b_irq_enable_bits_out  = pb_irq_en_q;
    assign port_b_irq_request_bits_out = pb_irq_req_q;
    assign port_a_pullup_bits_out      = pa_pull_q;
    assign port_b_pullup_bits_out      = pb_pull_q;
    assign port_c_pullup_bits_out      = pc_pull_q;
    assign port_d_pullup_bits_out      = pd_pull_q;
    assign port_e_pullup_bit_out       = pe_pull_q;
    assign table_busy_out              = table_busy_q;

endmodule : sysreg_rom_table_reader

// *** sim/sysreg_rom_table_reader_asserts.sv ***
// Port-level checks for the system register bank and table reader
`timescale 1ns/1ps
module sysreg_rom_table_reader_asserts
    import sysreg_rom_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic [9:0]  addr_in,
    input  wire logic        wr_en_in,
    input  wire logic [3:0]  wr_data_in,
    input  wire logic        rd_en_in,
    input  wire logic [3:0]  rd_data_out,
    input  wire logic        wdog_reset_in,
    input  wire logic [9:0]  conversion_result_in,
    input  wire logic [3:0]  port_b_fall_in,
    input  wire logic [2:0]  watchdog_ctrl_field_out,
    input  wire logic        watchdog_overflow_flag_out,
    input  wire logic [3:0]  pwm_a_control_out,
    input  wire logic [3:0]  pwm_b_control_out,
    input  wire logic [7:0]  pwm_a_period_out,
    input  wire logic [3:0]  port_b_irq_request_bits_out,
    input  wire logic        table_busy_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    // A watchdog reset overrides a same-cycle write, except to period, duty, fine and table address registers
    wire wr_ok = wr_en_in && !wdog_reset_in;

    property p_wdog_field;
        (wr_ok && addr_in == ADDR_WDOG_CTRL) |=> watchdog_ctrl_field_out == $past(wr_data_in[2:0]);
    endproperty
    a_wdog_field: assert property (p_wdog_field) else $error("watchdog field not written");
    property p_wdog_flag;
        !wdog_reset_in |=> !$rose(watchdog_overflow_flag_out);
    endproperty
    a_wdog_flag: assert property (p_wdog_flag) else $error("overflow flag set by write");
    property p_wdog_rst;
        wdog_reset_in |=> watchdog_overflow_flag_out && watchdog_ctrl_field_out == 3'h0
            && !pwm_a_control_out[0] && pwm_b_control_out[3:1] == $past(pwm_b_control_out[3:1]);
    endproperty
    a_wdog_rst: assert property (p_wdog_rst) else $error("watchdog reset state wrong");
    property p_ctrl_b;
        (wr_ok && addr_in == ADDR_PWM_B_CTRL) |=> pwm_b_control_out == $past(wr_data_in);
    endproperty
    a_ctrl_b: assert property (p_ctrl_b) else $error("channel b control not written");
    property p_period;
        (wr_ok && addr_in == ADDR_PWM_A_PLO) |=> pwm_a_period_out[3:0] == $past(wr_data_in)
            && $stable(pwm_a_period_out[7:4]);
    endproperty
    a_period: assert property (p_period) else $error("channel a period low wrong");
    property p_conv;
        (rd_en_in && addr_in == ADDR_CONV_HIGH) |=> rd_data_out == $past(conversion_result_in[9:6]);
    endproperty
    a_conv: assert property (p_conv) else $error("conversion high nibble wrong");
    property p_rd_zero;
        (!rd_en_in || addr_in == 10'h01d || addr_in == 10'h02c) |=> rd_data_out == 4'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("idle or reserved read not zero");
    property p_irq;
        !wdog_reset_in |=> (port_b_irq_request_bits_out & $past(port_b_fall_in)) == $past(port_b_fall_in);
    endproperty
    a_irq: assert property (p_irq) else $error("port b event not flagged");
    property p_busy;
        (wr_ok && addr_in == ADDR_TABLE_N0) |=> table_busy_out [*4];
    endproperty
    a_busy: assert property (p_busy) else $error("table fetch not busy four cycles");
endmodule : sysreg_rom_table_reader_asserts

// *** sim/sysreg_rom_table_reader_tb.sv ***
// Self-checking bench for the system register bank and table reader
`timescale 1ns/1ps
module sysreg_rom_table_reader_tb
    import sysreg_rom_pkg::*;
;
    logic        clock_in = 1'b0, reset_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
    logic        wdog_reset_in = 1'b0, prog_wr_en_in = 1'b0;
    logic [9:0]  addr_in = 10'h000, conversion_result_in = 10'h000;
    logic [3:0]  wr_data_in = 4'h0, port_b_fall_in = 4'h0, port_d_fall_in = 4'h0;
    logic [11:0] prog_addr_in = 12'h000, fetch_addr_in = 12'h000;
    logic [15:0] prog_data_in = 16'h0000, fetch_word_out;
    logic [9:0]  pwm_a_duty_out, pwm_b_duty_out;
    logic [7:0]  pwm_a_period_out, pwm_b_period_out;
    logic [3:0]  rd_data_out, port_c_dir_bits_out, port_d_dir_bits_out, pwm_a_control_out;
    logic [3:0]  pwm_b_control_out, port_d_irq_enable_bits_out, port_d_irq_request_bits_out;
    logic [3:0]  port_b_irq_enable_bits_out, port_b_irq_request_bits_out, port_a_pullup_bits_out;
    logic [3:0]  port_b_pullup_bits_out, port_c_pullup_bits_out, port_d_pullup_bits_out;
    logic [2:0]  watchdog_ctrl_field_out;
    logic        port_e_dir_bit_out, watchdog_overflow_flag_out, port_e_pullup_bit_out;
    logic        table_busy_out;
    int          mismatches = 0;
    int          samples_checked = 0;
    logic [9:0]  rw_addr [24] = '{10'h01a, 10'h01b, 10'h01c, 10'h020, 10'h021, 10'h022, 10'h023,
        10'h024, 10'h025, 10'h026, 10'h027, 10'h028, 10'h029, 10'h02a, 10'h02b, 10'h384, 10'h385,
        10'h386, 10'h387, 10'h388, 10'h389, 10'h38a, 10'h38b, 10'h38c};
    logic [9:0]  ro_addr [8] = '{10'h01d, 10'h01f, 10'h02c, 10'h02d, 10'h02e, 10'h02f, 10'h383,
        10'h100};

    sysreg_rom_table_reader u_dut (.addr_in, .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out,
        .clock_in, .reset_in, .wdog_reset_in, .conversion_result_in, .port_b_fall_in,
        .port_d_fall_in, .prog_wr_en_in, .prog_addr_in, .prog_data_in, .fetch_addr_in,
        .fetch_word_out, .port_c_dir_bits_out, .port_d_dir_bits_out, .port_e_dir_bit_out,
        .watchdog_ctrl_field_out, .watchdog_overflow_flag_out, .pwm_a_control_out,
        .pwm_b_control_out, .pwm_a_period_out, .pwm_b_period_out, .pwm_a_duty_out,
        .pwm_b_duty_out, .port_d_irq_enable_bits_out, .port_d_irq_request_bits_out,
        .port_b_irq_enable_bits_out, .port_b_irq_request_bits_out, .port_a_pullup_bits_out,
        .port_b_pullup_bits_out, .port_c_pullup_bits_out, .port_d_pullup_bits_out,
        .port_e_pullup_bit_out, .table_busy_out);

    always #5 clock_in = ~clock_in;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [3:0] d);
        addr_in = a;
        wr_data_in = d;
        wr_en_in = 1'b1;
        @(negedge clock_in);
        wr_en_in = 1'b0;
        @(negedge clock_in);
    endtask : wr

    task automatic rdc(input logic [9:0] a, input logic [3:0] e);
        addr_in = a;
        rd_en_in = 1'b1;
        @(negedge clock_in);
        rd_en_in = 1'b0;
        chk(16'(rd_data_out), 16'(e));
        @(negedge clock_in);
    endtask : rdc

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (8) @(negedge clock_in);
        reset_in = 1'b0;
        @(negedge clock_in);
        rdc(ADDR_WDOG_CTRL, 4'h0);
        for (int i = 0; i < 24; i++) begin
            wr(rw_addr[i], rw_addr[i][3:0] ^ 4'h5);
            rdc(rw_addr[i], (rw_addr[i][3:0] ^ 4'h5) & ((i == 2 || i == 23) ? 4'h1 :
                (i == 7 || i == 12) ? 4'h3 : 4'hf));
        end
        chk(16'(pwm_a_control_out), 16'h0005);
        chk(16'(pwm_b_control_out), 16'h0004);
        chk(16'(pwm_a_period_out), 16'h0067);
        chk(16'(pwm_a_duty_out), 16'h00c1);
        chk(16'(pwm_b_period_out), 16'h00d2);
        chk(16'(pwm_b_duty_out), 16'h03bc);
        chk({port_c_dir_bits_out, port_d_dir_bits_out, port_d_irq_enable_bits_out,
            port_d_irq_request_bits_out}, 16'hfe10);
        chk({port_b_irq_enable_bits_out, port_b_irq_request_bits_out, port_a_pullup_bits_out,
            port_b_pullup_bits_out}, 16'h32dc);
        chk({port_c_pullup_bits_out, port_d_pullup_bits_out, 6'h00, port_e_dir_bit_out,
            port_e_pullup_bit_out}, 16'hfe03);
        $display("test registers done");
        wr(ADDR_WDOG_CTRL, 4'hf);
        rdc(ADDR_WDOG_CTRL, 4'h7);
        wdog_reset_in = 1'b1;
        @(negedge clock_in);
        wdog_reset_in = 1'b0;
        rdc(ADDR_WDOG_CTRL, 4'h8);
        chk(16'(pwm_a_control_out), 16'h0004);
        wr(ADDR_WDOG_CTRL, 4'h0);
        rdc(ADDR_WDOG_CTRL, 4'h8);
        $display("test watchdog done");
        foreach (ro_addr[i]) begin
            wr(ro_addr[i], 4'hf);
            rdc(ro_addr[i], 4'h0);
        end
        conversion_result_in = 10'h2b6;
        rdc(ADDR_CONV_LOW, 4'h2);
        rdc(ADDR_CONV_MID, 4'hd);
        rdc(ADDR_CONV_HIGH, 4'ha);
        $display("test read-only done");
        prog_wr_en_in = 1'b1;
        for (int i = 0; i < 6; i++) begin
            prog_addr_in = (i == 5) ? 12'hfff : 12'(i);
            prog_data_in = (i == 5) ? 16'h5a3c : (16'ha000 | 16'(i));
            @(negedge clock_in);
        end
        prog_wr_en_in = 1'b0;
        for (int i = 0; i < 6; i++) begin
            fetch_addr_in = (i == 5) ? 12'hfff : 12'(i);
            @(negedge clock_in);
            chk(fetch_word_out, (i == 5) ? 16'h5a3c : (16'ha000 | 16'(i)));
        end
        for (int i = 2; i >= 0; i--) wr(ADDR_TABLE_N0 + 10'(i), 4'hf);
        chk(16'(table_busy_out), 16'h0001);
        rdc(ADDR_TABLE_N3, 4'h0);
        @(negedge clock_in);
        chk(16'(table_busy_out), 16'h0000);
        for (int i = 0; i < 4; i++) rdc(ADDR_TABLE_N0 + 10'(i), 4'(16'h5a3c >> (4 * i)));
        for (int i = 2; i >= 0; i--) wr(ADDR_TABLE_N0 + 10'(i), (i == 0) ? 4'h4 : 4'h0);
        wr(ADDR_TABLE_N0, 4'h2);
        @(negedge clock_in);
        chk(16'(table_busy_out), 16'h0001);
        repeat (2) @(negedge clock_in);
        rdc(ADDR_TABLE_N0, 4'h2);
        rdc(ADDR_TABLE_N3, 4'ha);
        $display("test table read done");
        port_b_fall_in = 4'h4;
        port_d_fall_in = 4'h8;
        @(negedge clock_in);
        port_b_fall_in = 4'h0;
        port_d_fall_in = 4'h0;
        rdc(ADDR_PB_IRQ_REQ, 4'h4);
        rdc(ADDR_PD_IRQ_REQ, 4'h8);
        wr(ADDR_PB_IRQ_REQ, 4'h0);
        rdc(ADDR_PB_IRQ_REQ, 4'h0);
        $display("test port events done");
        finish_test();
    end

    initial begin
        repeat (3000) @(posedge clock_in);
        mismatches++;
        $display("CHECK FAILED at %0t: timeout", $time);
        finish_test();
    end
endmodule : sysreg_rom_table_reader_tb

bind sysreg_rom_table_reader sysreg_rom_table_reader_asserts u_chk (.clock_in, .reset_in,
    .addr_in, .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out, .wdog_reset_in,
    .conversion_result_in, .port_b_fall_in, .watchdog_ctrl_field_out,
    .watchdog_overflow_flag_out, .pwm_a_control_out, .pwm_b_control_out, .pwm_a_period_out,
    .port_b_irq_request_bits_out, .table_busy_out);
